// >>> asf_regs.svh
// Register offsets, field positions, codes and reset values of the status flags block
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH
`define ASF_ADDR_STATUS 4'h0
`define ASF_ADDR_IRQ_STAT 4'h1
`define ASF_ADDR_IRQ_CLR 4'h2
`define ASF_ADDR_IRQ_EN 4'h3
`define ASF_ADDR_RATE_VLD 4'h4
`define ASF_BIT_RDY 0
`define ASF_BIT_MBUSY 1
`define ASF_PD_LSB 2
`define ASF_RATE_LSB 4
`define ASF_BIT_AOR 8
`define ASF_BIT_DOR 9
`define ASF_BIT_GOR 10
`define ASF_PD_CONV 2'h0
`define ASF_PD_SLEEP 2'h1
`define ASF_PD_STBY 2'h2
`define ASF_PD_RST 2'h3
`define ASF_SEQ_MODE1 2'h1
`define ASF_GAIN_MAX 32'hffff_ffff
`define ASF_GAIN_RST 32'h8000_0000
`define ASF_DATA_MAX 24'h7f_ffff
`define ASF_DATA_MIN 24'h80_0000
`define ASF_IRQ_W 4
`define ASF_IRQ_RDY 0
`define ASF_IRQ_DOR 1
`define ASF_IRQ_AOR 2
`define ASF_IRQ_GOR 3
`define ASF_ZERO24 24'h00_0000
`define ASF_ZERO4 4'h0
`endif

// >>> asf_pkg.sv
// Types shared by the status flags block
package asf_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [23:0] wdata;
		logic wr;
		logic rd;
	} asf_bus_type;
	typedef struct packed {
		logic valid;
		logic [25:0] raw;
		logic [3:0] rate;
	} asf_result_type;
endpackage

// >>> asf_clip.sv
// Clips a raw conversion word to the 24-bit two's complement range
`include "asf_regs.svh"
module asf_clip
	import asf_pkg::*;
(
	input wire logic [25:0] raw,
	output logic [23:0] clipped,
	output logic over
);
	always_comb
	begin
		if (raw[25] == 1'b0 && raw[24:23] != 2'b00)
		begin
			clipped = `ASF_DATA_MAX;
			over = 1'b1;
		end
		else if (raw[25] == 1'b1 && raw[24:23] != 2'b11)
		begin
			clipped = `ASF_DATA_MIN;
			over = 1'b1;
		end
		else
		begin
			clipped = raw[23:0];
			over = 1'b0;
		end
	end
endmodule

// >>> asf_status_flags.sv
// Status flags of a delta-sigma converter: overrange, rate, power state, busy, ready
//
// Added by the designer: the address map and the plain strobed port.
`include "asf_regs.svh"
module asf_status_flags
	import asf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire asf_bus_type bus,
	output logic [23:0] rdata,
	input wire asf_result_type result,
	input wire logic [1:0] seq_mode,
	input wire logic data_read_done,
	input wire logic data_read_partial,
	input wire logic [1:0] power_state,
	input wire logic conv_active,
	input wire logic cal_active,
	input wire logic mod_sample_vld,
	input wire logic [23:0] mod_input_mag,
	input wire logic [7:0] pga_gain,
	input wire logic [23:0] ref_mag,
	input wire logic gain_cal_done,
	input wire logic [32:0] gain_cal_coef,
	output logic [31:0] gain_coef,
	output logic [23:0] data_out,
	output logic result_ready_pin,
	output logic irq
);
	typedef struct packed {
		logic [23:0] rdata;
		logic [23:0] data;
		logic [31:0] gain;
		logic rdy;
		logic mbusy;
		logic [1:0] pd;
		logic [3:0] rate;
		logic rate_vld;
		logic analog_overrange_flag;
		logic digital_overrange_flag;
		logic gor;
		logic [3:0] irq_stat;
		logic [3:0] irq_en;
		logic irq;
		logic rdy_pin;
	} asf_state_type;

	asf_state_type st_ff;
	asf_state_type nxt_st;
	logic [23:0] clipped;
	logic clip_over;
	logic [3:0] events;
	logic [31:0] gained;

	asf_clip u_clip
	(
		.raw(result.raw),
		.clipped(clipped),
		.over(clip_over)
	);

	// Magnitude times gain, widened so a large gain cannot wrap
	function automatic logic [31:0] asf_gain_mul(input logic [23:0] mag, input logic [7:0] g);
		asf_gain_mul = {8'h00, mag} * {24'h00_0000, g};
	endfunction

	function automatic logic [23:0] asf_status_word(input asf_state_type s);
		logic [23:0] w;
		w = `ASF_ZERO24;
		w[`ASF_BIT_RDY] = s.rdy;
		w[`ASF_BIT_MBUSY] = s.mbusy;
		w[`ASF_PD_LSB +: 2] = s.pd;
		w[`ASF_RATE_LSB +: 4] = s.rate;
		w[`ASF_BIT_AOR] = s.analog_overrange_flag;
		w[`ASF_BIT_DOR] = s.digital_overrange_flag;
		w[`ASF_BIT_GOR] = s.gor;
		asf_status_word = w;
	endfunction

	assign gained = asf_gain_mul(mod_input_mag, pga_gain);

	always_comb
	begin
		nxt_st = st_ff;
		events = `ASF_ZERO4;
		nxt_st.pd = power_state;
		nxt_st.mbusy = conv_active | cal_active;
		if (mod_sample_vld)
		begin
			// Gained level against reference; flag follows the latest sample
			nxt_st.analog_overrange_flag = gained > {8'h00, ref_mag};
			events[`ASF_IRQ_AOR] = nxt_st.analog_overrange_flag;
		end
		if (gain_cal_done)
		begin
			nxt_st.gor = gain_cal_coef[32];
			nxt_st.gain = gain_cal_coef[32] ? `ASF_GAIN_MAX : gain_cal_coef[31:0];
			events[`ASF_IRQ_GOR] = gain_cal_coef[32];
			nxt_st.rate = result.rate;
			nxt_st.rate_vld = 1'b1;
		end
		if (data_read_done)
		begin
			nxt_st.rate_vld = 1'b0;
			nxt_st.rdy = 1'b0;
		end
		// Partial reads never touch ready
		if (data_read_partial && !data_read_done)
		begin
			nxt_st.rdy = st_ff.rdy;
		end
		if (result.valid)
		begin
			nxt_st.data = clipped;
			nxt_st.digital_overrange_flag = clip_over;
			events[`ASF_IRQ_DOR] = clip_over;
			nxt_st.rate = result.rate;
			nxt_st.rate_vld = 1'b1;
			// In mode 1 a new result wins over a clearing read in the same cycle
			if (seq_mode == `ASF_SEQ_MODE1)
			begin
				nxt_st.rdy = 1'b1;
				events[`ASF_IRQ_RDY] = 1'b1;
			end
		end
		nxt_st.rdy_pin = nxt_st.rdy;
		if (bus.wr && bus.addr == `ASF_ADDR_IRQ_CLR)
		begin
			nxt_st.irq_stat = st_ff.irq_stat & ~bus.wdata[`ASF_IRQ_W-1:0];
		end
		if (bus.wr && bus.addr == `ASF_ADDR_IRQ_EN)
		begin
			nxt_st.irq_en = bus.wdata[`ASF_IRQ_W-1:0];
		end
		// Set beats clear
		nxt_st.irq_stat = nxt_st.irq_stat | events;
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);
		nxt_st.rdata = `ASF_ZERO24;
		if (bus.rd)
		begin
			unique case (bus.addr)
				`ASF_ADDR_STATUS: nxt_st.rdata = asf_status_word(st_ff);
				`ASF_ADDR_IRQ_STAT: nxt_st.rdata = {20'h0_0000, st_ff.irq_stat};
				`ASF_ADDR_IRQ_EN: nxt_st.rdata = {20'h0_0000, st_ff.irq_en};
				`ASF_ADDR_RATE_VLD: nxt_st.rdata = {23'h00_0000, st_ff.rate_vld};
				default: nxt_st.rdata = `ASF_ZERO24;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_ff <= '0;
			st_ff.pd <= `ASF_PD_STBY;
			st_ff.gain <= `ASF_GAIN_RST;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign rdata = st_ff.rdata;
	assign gain_coef = st_ff.gain;
	assign data_out = st_ff.data;
	assign result_ready_pin = st_ff.rdy_pin;
	assign irq = st_ff.irq;

	chk_ready_sets: assert property (@(posedge clk) disable iff (!rst_n)
		result.valid && seq_mode == `ASF_SEQ_MODE1 |=> result_ready_pin)
		else $error("ready not set after new result");
	chk_ready_clears: assert property (@(posedge clk) disable iff (!rst_n)
		data_read_done && !result.valid |=> !st_ff.rdy)
		else $error("ready not cleared by full read");
	chk_partial_keeps: assert property (@(posedge clk) disable iff (!rst_n)
		data_read_partial && !data_read_done && st_ff.rdy |=> st_ff.rdy)
		else $error("partial read cleared ready");
	chk_pin_mirror: assert property (@(posedge clk) disable iff (!rst_n)
		bus.rd && bus.addr == `ASF_ADDR_STATUS |=> rdata[`ASF_BIT_RDY] == $past(result_ready_pin))
		else $error("ready pin differs from flag");
	chk_gain_clamp: assert property (@(posedge clk) disable iff (!rst_n)
		gain_cal_done && gain_cal_coef[32] |=> st_ff.gor && gain_coef == `ASF_GAIN_MAX)
		else $error("gain overrange not clamped");
	chk_dor_track: assert property (@(posedge clk) disable iff (!rst_n)
		result.valid |=> st_ff.digital_overrange_flag == $past(clip_over))
		else $error("digital overrange wrong");
	chk_aor_gain: assert property (@(posedge clk) disable iff (!rst_n)
		mod_sample_vld |=> st_ff.analog_overrange_flag == ($past(gained) > {8'h00, $past(ref_mag)}))
		else $error("analog overrange wrong");
	chk_busy_level: assert property (@(posedge clk) disable iff (!rst_n)
		!conv_active && !cal_active |=> !st_ff.mbusy)
		else $error("busy high while idle");
	chk_rate_invalid: assert property (@(posedge clk) disable iff (!rst_n)
		data_read_done && !result.valid && !gain_cal_done |=> !st_ff.rate_vld)
		else $error("rate still valid after read");
	chk_write_ro: assert property (@(posedge clk) disable iff (!rst_n)
		bus.wr && bus.addr == `ASF_ADDR_STATUS && !result.valid && !data_read_done
		&& !gain_cal_done && !mod_sample_vld |=> $stable(st_ff.rdy) && $stable(st_ff.digital_overrange_flag))
		else $error("status write changed a flag");

	// Building blocks for the checks below
	sequence seq_new_result;
		result.valid && seq_mode == `ASF_SEQ_MODE1;
	endsequence
	sequence seq_full_read;
		data_read_done && !result.valid;
	endsequence
	sequence seq_status_rd;
		bus.rd && bus.addr == `ASF_ADDR_STATUS;
	endsequence
	sequence seq_clip_high;
		result.valid && !result.raw[25] && result.raw[24:23] != 2'b00;
	endsequence
	sequence seq_clip_low;
		result.valid && result.raw[25] && result.raw[24:23] != 2'b11;
	endsequence

	// Ready flag life cycle
	chk_ready_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
		seq_new_result ##1 seq_full_read |=> !result_ready_pin)
		else $error("ready survived a full read");

	// A result landing with the read must not be lost
	chk_new_beats_read: assert property (@(posedge clk) disable iff (!rst_n)
		result.valid && seq_mode == `ASF_SEQ_MODE1 && data_read_done |=> st_ff.rdy)
		else $error("same-cycle read dropped new result");

	chk_ready_other_mode: assert property (@(posedge clk) disable iff (!rst_n)
		result.valid && seq_mode != `ASF_SEQ_MODE1 && !st_ff.rdy |=> !st_ff.rdy)
		else $error("ready set outside single mode");

	chk_ready_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!result.valid && !data_read_done |=> $stable(st_ff.rdy))
		else $error("ready moved without cause");

	// Power and busy follow the core levels
	chk_pd_follow: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> st_ff.pd == $past(power_state))
		else $error("power state not tracked");

	chk_busy_active: assert property (@(posedge clk) disable iff (!rst_n)
		conv_active || cal_active |=> st_ff.mbusy)
		else $error("busy low while active");

	// Gain calibration outcome
	chk_gain_pass: assert property (@(posedge clk) disable iff (!rst_n)
		gain_cal_done && !gain_cal_coef[32]
		|=> !st_ff.gor && gain_coef == $past(gain_cal_coef[31:0]))
		else $error("in-range gain not loaded");

	chk_gain_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!gain_cal_done |=> $stable(gain_coef) && $stable(st_ff.gor))
		else $error("gain changed without calibration");

	// Clipping of results
	chk_clip_max: assert property (@(posedge clk) disable iff (!rst_n)
		seq_clip_high |=> data_out == `ASF_DATA_MAX && st_ff.digital_overrange_flag)
		else $error("positive clip wrong");

	chk_clip_min: assert property (@(posedge clk) disable iff (!rst_n)
		seq_clip_low |=> data_out == `ASF_DATA_MIN && st_ff.digital_overrange_flag)
		else $error("negative clip wrong");

	chk_in_range: assert property (@(posedge clk) disable iff (!rst_n)
		result.valid && !clip_over |=> !st_ff.digital_overrange_flag && data_out == $past(result.raw[23:0]))
		else $error("in-range result altered");

	chk_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!result.valid |=> $stable(data_out) && $stable(st_ff.digital_overrange_flag))
		else $error("data changed without result");

	// Analog overrange only moves on a sample
	chk_aor_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!mod_sample_vld |=> $stable(st_ff.analog_overrange_flag))
		else $error("analog overrange moved without sample");

	chk_aor_unity: assert property (@(posedge clk) disable iff (!rst_n)
		mod_sample_vld && pga_gain == 8'h01 |=> st_ff.analog_overrange_flag == ($past(mod_input_mag) > $past(ref_mag)))
		else $error("analog overrange wrong at unity gain");

	// Rate code bookkeeping
	chk_rate_result: assert property (@(posedge clk) disable iff (!rst_n)
		result.valid |=> st_ff.rate == $past(result.rate) && st_ff.rate_vld)
		else $error("rate not loaded with result");

	chk_rate_cal: assert property (@(posedge clk) disable iff (!rst_n)
		gain_cal_done && !result.valid |=> st_ff.rate == $past(result.rate) && st_ff.rate_vld)
		else $error("rate not loaded with calibration");

	chk_rate_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!result.valid && !gain_cal_done |=> $stable(st_ff.rate))
		else $error("rate changed without cause");

	// Register reads show the flags as they stood
	chk_status_read: assert property (@(posedge clk) disable iff (!rst_n)
		seq_status_rd |=> rdata[`ASF_RATE_LSB +: 4] == $past(st_ff.rate)
		&& rdata[`ASF_PD_LSB +: 2] == $past(st_ff.pd))
		else $error("status read shows wrong fields");

	chk_status_flags_read: assert property (@(posedge clk) disable iff (!rst_n)
		seq_status_rd |=> rdata[`ASF_BIT_AOR] == $past(st_ff.analog_overrange_flag)
		&& rdata[`ASF_BIT_DOR] == $past(st_ff.digital_overrange_flag) && rdata[`ASF_BIT_GOR] == $past(st_ff.gor))
		else $error("status read shows wrong flags");

	chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!bus.rd |=> rdata == `ASF_ZERO24)
		else $error("read data without read");

	chk_write_status_gain: assert property (@(posedge clk) disable iff (!rst_n)
		bus.wr && bus.addr == `ASF_ADDR_STATUS && !gain_cal_done |=> $stable(gain_coef))
		else $error("status write changed gain");

	// Interrupt block
	chk_irq_en_write: assert property (@(posedge clk) disable iff (!rst_n)
		bus.wr && bus.addr == `ASF_ADDR_IRQ_EN |=> st_ff.irq_en == $past(bus.wdata[`ASF_IRQ_W-1:0]))
		else $error("enable write lost");

	chk_irq_ready_event: assert property (@(posedge clk) disable iff (!rst_n)
		seq_new_result |=> st_ff.irq_stat[`ASF_IRQ_RDY])
		else $error("ready event not latched");

	chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
		irq == |(st_ff.irq_stat & st_ff.irq_en))
		else $error("interrupt level wrong");

	// Sticky until written with a one
	chk_irq_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		st_ff.irq_stat[`ASF_IRQ_DOR] && !(bus.wr && bus.addr == `ASF_ADDR_IRQ_CLR)
		|=> st_ff.irq_stat[`ASF_IRQ_DOR])
		else $error("sticky bit dropped");

	chk_irq_clear: assert property (@(posedge clk) disable iff (!rst_n)
		bus.wr && bus.addr == `ASF_ADDR_IRQ_CLR && bus.wdata[`ASF_IRQ_RDY] && !result.valid
		|=> !st_ff.irq_stat[`ASF_IRQ_RDY])
		else $error("clear write ignored");
endmodule

// >>> asf_host_model.sv
// Host side model: issues partial and complete reads of the data register
module asf_host_model (
	input wire logic clk,
	input wire logic part_go,
	input wire logic full_go,
	output logic data_read_partial,
	output logic data_read_done
);
	timeunit 1ns;
	timeprecision 1ns;
	initial data_read_partial = 1'b0;
	initial data_read_done = 1'b0;
	// Ready flag is never consulted, so modes 2 and 3 are safe
	always @(posedge clk)
	begin
		data_read_partial <= part_go;
		data_read_done <= full_go;
	end
endmodule

// >>> asf_status_flags_test.sv
// Self-checking bench of the status flags block
`include "asf_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] %0t got %h", $time, a); end end
module asf_status_flags_test import asf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, conv = 0, cal = 0, msv = 0, gcd = 0, part_go = 0, full_go = 0;
	asf_bus_type bus = '0;
	asf_result_type res = '0;
	logic [1:0] sm = 2'h1, ps = 2'h2;
	logic [23:0] mag = '0, refm = '0, rdata, dout, rv;
	logic [7:0] gain = 8'h1;
	logic [32:0] gcc = '0;
	logic [31:0] gcoef;
	logic pin, irq, done, part;
	int fails = 0, tests_run = 0;
	asf_host_model asf_host_model_inst (.clk(clk), .part_go(part_go), .full_go(full_go),
		.data_read_partial(part), .data_read_done(done));
	asf_status_flags asf_status_flags_inst (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.result(res), .seq_mode(sm), .data_read_done(done), .data_read_partial(part),
		.power_state(ps), .conv_active(conv), .cal_active(cal), .mod_sample_vld(msv),
		.mod_input_mag(mag), .pga_gain(gain), .ref_mag(refm), .gain_cal_done(gcd),
		.gain_cal_coef(gcc), .gain_coef(gcoef), .data_out(dout), .result_ready_pin(pin),
		.irq(irq));
	initial forever #4 clk = ~clk;
	task automatic wr(logic [3:0] a, logic [23:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(logic [3:0] a);
		@(posedge clk);
		bus <= '{a, 24'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 rv = rdata;
	endtask
	// Ends every pulse after one cycle
	task automatic step;
		@(posedge clk);
		res.valid <= 0; msv <= 0; gcd <= 0; part_go <= 0; full_go <= 0;
		#1;
	endtask
	task automatic close_out;
		$display("errors %0d of %0d checks", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		fails++;
		close_out;
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		rd(4'h0); `CHK(rv, 24'h8)
		`CHK(gcoef, 32'h8000_0000)
		wr(4'h0, 24'hff_ffff); rd(4'h0); `CHK(rv, 24'h8)
		wr(4'h3, 24'h3);
		rd(4'h3); `CHK(rv, 24'h3)
		@(posedge clk) res <= '{1'b1, 26'h0ff_ffff, 4'h5};
		step; `CHK(pin, 1'b1)
		`CHK(dout, 24'h7f_ffff)
		`CHK(irq, 1'b1)
		rd(4'h0); `CHK(rv, 24'h259)
		rd(4'h4); `CHK(rv, 24'h1)
		rd(4'h1); `CHK(rv, 24'h3)
		wr(4'h2, 24'h3); step; `CHK(irq, 1'b0)
		@(posedge clk) res <= '{1'b1, 26'h200_0000, 4'h3};
		step; `CHK(dout, 24'h80_0000)
		@(posedge clk) res <= '{1'b1, 26'h000_0010, 4'h3};
		step; `CHK(dout, 24'h10)
		rd(4'h0); `CHK(rv, 24'h39)
		@(posedge clk) part_go <= 1;
		step; step; `CHK(pin, 1'b1)
		@(posedge clk) full_go <= 1;
		step; step; `CHK(pin, 1'b0)
		rd(4'h4); `CHK(rv, 24'h0)
		@(posedge clk) {sm, res} <= {2'h2, 1'b1, 26'h000_0020, 4'h7};
		step; `CHK(pin, 1'b0)
		`CHK(dout, 24'h20)
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk) {cal, conv} <= i[1:0];
			ps <= i[1:0];
			rd(4'h0); `CHK(rv[3:0], {i[1:0], i != 0, 1'b0})
		end
		@(posedge clk) {msv, mag, gain, refm} <= {1'b1, 24'h64, 8'h2, 24'h96};
		step; rd(4'h0); `CHK(rv[8], 1'b1)
		@(posedge clk) {msv, gain} <= {1'b1, 8'h1};
		step; rd(4'h0); `CHK(rv[8], 1'b0)
		@(posedge clk) {gcd, gcc} <= {1'b1, 33'h1_0000_1234};
		step; `CHK(gcoef, 32'hffff_ffff)
		rd(4'h0); `CHK(rv[10], 1'b1)
		rd(4'hf); `CHK(rv, 24'h0)
		@(posedge clk) {gcd, gcc} <= {1'b1, 33'h0_1234_5678};
		step; `CHK(gcoef, 32'h1234_5678)
		rd(4'h0); `CHK(rv[10], 1'b0)
		close_out;
	end
endmodule
